/* File: hw/amdr_record.sv */
// diagnostic record of a four-channel analog input module
`timescale 1ns/1ps
// Function
// - summary bits 0-3: fail, internal, external, channel
// - summary bit 4 aux supply, bit 7 parameters
// - info byte class field reads analog 0101b
// - info bit 4 marks channel information present
// - extended bit 3 diagnostics buffer overflow
// - extended bit 4 internal communication error
// - channel type byte reads analog input code
// - diagnostic bits per channel reads 08h
// - channel count byte reads 04h
// - group byte bit n flags group n error
// - channel byte bit 0 parameter error
// - channel byte bit 6 underflow, 7 overflow
// - channel bytes for channels 4-7 reserved
// - ticker captured into timestamp on diagnostic
// - ticker cleared at reset, counts upward
// - ticker wraps to zero after maximum
// - channel errors light their channel LED, module errors none, no interrupt
// - set 01h whole record, 00h four bytes
module amdr_record
  import amdr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // module level error sources
  input wire logic MOD_FAIL,
  input wire logic INT_ERR,
  input wire logic EXT_ERR,
  input wire logic AUX_MISSING,
  input wire logic PARAM_ERR,
  input wire logic DIAG_BUF_OVF,
  input wire logic COMM_ERR,
  // channel error sources, one bit per channel
  input wire logic [3:0] CH_PARAM_ERR,
  input wire logic [3:0] CH_UNDER,
  input wire logic [3:0] CH_OVER,
  // record read request
  input wire logic RD_REQ,
  input wire logic [7:0] RECORD_SET_NUMBER,
  input wire logic [4:0] RD_INDEX,
  // record read answer
  output logic RD_ACK,
  output logic RD_NACK,
  output logic [7:0] RD_DATA,
  // indicators and ticker
  output logic [3:0] CH_LED,
  output logic [31:0] US_TICKER
);

  logic [7:0] summary_reg;
  logic [7:0] summary_next;
  logic [7:0] ext_reg;
  logic [7:0] ext_next;
  logic [7:0] group_reg;
  logic [7:0] group_next;
  logic [7:0] channel_group_errors_reg [AMDR_CHANNELS];
  logic [7:0] channel_group_errors_next [AMDR_CHANNELS];
  logic [31:0] ts_reg;
  logic [31:0] ts_next;
  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  logic [6:0] presc_reg;
  logic [6:0] presc_next;
  logic [3:0] led_reg;
  logic [3:0] led_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic nack_reg;
  logic nack_next;

  logic [3:0] ch_any;
  logic new_event;
  logic [7:0] info_byte;
  logic [7:0] chtype_byte;
  logic [7:0] sel_byte;
  logic [4:0] last_idx;
  logic set_ok;

  // status capture
  always_comb begin
    ch_any = CH_PARAM_ERR | CH_UNDER | CH_OVER;
    summary_next = AMDR_BYTE_RST;
    summary_next[AMDR_SUM_FAIL] = MOD_FAIL;
    summary_next[AMDR_SUM_INT] = INT_ERR;
    summary_next[AMDR_SUM_EXT] = EXT_ERR;
    summary_next[AMDR_SUM_CHAN] = |ch_any;
    summary_next[AMDR_SUM_AUX] = AUX_MISSING;
    summary_next[AMDR_SUM_PARAM] = PARAM_ERR;
    ext_next = AMDR_BYTE_RST;
    ext_next[AMDR_EXT_OVF] = DIAG_BUF_OVF;
    ext_next[AMDR_EXT_COMM] = COMM_ERR;
    group_next = {4'h0, ch_any};
    for (int i = 0; i < AMDR_CHANNELS; i++) begin
      channel_group_errors_next[i] = AMDR_BYTE_RST;
      channel_group_errors_next[i][AMDR_CH_PARAM] = CH_PARAM_ERR[i];
      channel_group_errors_next[i][AMDR_CH_UNDER] = CH_UNDER[i];
      channel_group_errors_next[i][AMDR_CH_OVER] = CH_OVER[i];
    end
    // channel LED follows its error, nothing is signalled upward
    led_next = ch_any;
  end

  // any error bit newly rising counts as a diagnostic event
  always_comb begin
    new_event = |(summary_next & ~summary_reg) | |(ext_next & ~ext_reg);
    for (int i = 0; i < AMDR_CHANNELS; i++) begin
      new_event = new_event | |(channel_group_errors_next[i] & ~channel_group_errors_reg[i]);
    end
  end

  // microsecond ticker and timestamp
  always_comb begin
    presc_next = presc_reg + 7'h01;
    tick_next = tick_reg;
    if (presc_reg == AMDR_US_LAST) begin
      presc_next = AMDR_PRESC_RST;
      // natural 32-bit rollover returns to zero
      tick_next = tick_reg + 32'h0000_0001;
    end
    ts_next = ts_reg;
    if (new_event) begin
      ts_next = tick_reg;
    end
  end

  // constant bytes
  always_comb begin
    info_byte = AMDR_BYTE_RST;
    info_byte[3:0] = AMDR_CLASS_ANALOG;
    info_byte[AMDR_INFO_CHPRES] = 1'b1;
    chtype_byte = {1'b0, AMDR_CHTYPE_AI};
  end

  // byte selection; reserved places fall to zero
  always_comb begin
    sel_byte = AMDR_BYTE_RST;
    if (RD_INDEX == AMDR_IDX_SUMMARY) begin
      sel_byte = summary_reg;
    end else if (RD_INDEX == AMDR_IDX_INFO) begin
      sel_byte = info_byte;
    end else if (RD_INDEX == AMDR_IDX_RSVD_C) begin
      sel_byte = AMDR_BYTE_RST;
    end else if (RD_INDEX == AMDR_IDX_EXT) begin
      sel_byte = ext_reg;
    end else if (RD_INDEX == AMDR_IDX_CHTYPE) begin
      sel_byte = chtype_byte;
    end else if (RD_INDEX == AMDR_IDX_DIAG_BITS_PER_CHANNEL) begin
      sel_byte = AMDR_DIAG_BITS_PER_CHANNEL;
    end else if (RD_INDEX == AMDR_IDX_CHANNEL_COUNT) begin
      sel_byte = AMDR_CHANNEL_COUNT;
    end else if (RD_INDEX == AMDR_IDX_GROUP) begin
      sel_byte = group_reg;
    end else if (RD_INDEX >= AMDR_IDX_CH0 && RD_INDEX <= AMDR_IDX_CH3) begin
      sel_byte = channel_group_errors_reg[2'(RD_INDEX - AMDR_IDX_CH0)];
    end else if (RD_INDEX >= AMDR_IDX_UNUSED0 &&
                 RD_INDEX <= AMDR_IDX_UNUSED3) begin
      sel_byte = AMDR_BYTE_RST;
    end else if (RD_INDEX >= AMDR_IDX_TS0 && RD_INDEX <= AMDR_IDX_TS3) begin
      // timestamp low byte first
      unique case (2'(RD_INDEX - AMDR_IDX_TS0))
        2'h0: sel_byte = ts_reg[7:0];
        2'h1: sel_byte = ts_reg[15:8];
        2'h2: sel_byte = ts_reg[23:16];
        2'h3: sel_byte = ts_reg[31:24];
      endcase
    end
  end

  // read answer; short set stops after byte 3
  // one request per cycle, answered on the next edge;
  // a refused read also clears the data byte so that a
  // coupler never mistakes stale data for a fresh answer;
  // the index limit depends on the requested record set
  // and any unknown set number is refused outright

  always_comb begin
    set_ok = 1'b1;
    last_idx = AMDR_LAST_FULL;
    if (RECORD_SET_NUMBER == AMDR_SET_SHORT) begin
      last_idx = AMDR_LAST_SHORT;
    end else if (RECORD_SET_NUMBER != AMDR_SET_FULL) begin
      set_ok = 1'b0;
    end
    ack_next = 1'b0;
    nack_next = 1'b0;
    rdata_next = rdata_reg;
    if (RD_REQ) begin
      if (set_ok && RD_INDEX <= last_idx) begin
        ack_next = 1'b1;
        rdata_next = sel_byte;
      end else begin
        nack_next = 1'b1;
        rdata_next = AMDR_BYTE_RST;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      summary_reg <= AMDR_BYTE_RST;
      ext_reg <= AMDR_BYTE_RST;
      group_reg <= AMDR_BYTE_RST;
      for (int i = 0; i < AMDR_CHANNELS; i++) begin
        channel_group_errors_reg[i] <= AMDR_BYTE_RST;
      end
      ts_reg <= AMDR_TICK_RST;
      tick_reg <= AMDR_TICK_RST;
      presc_reg <= AMDR_PRESC_RST;
      led_reg <= 4'h0;
      rdata_reg <= AMDR_BYTE_RST;
      ack_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      summary_reg <= summary_next;
      ext_reg <= ext_next;
      group_reg <= group_next;
      for (int i = 0; i < AMDR_CHANNELS; i++) begin
        channel_group_errors_reg[i] <= channel_group_errors_next[i];
      end
      ts_reg <= ts_next;
      tick_reg <= tick_next;
      presc_reg <= presc_next;
      led_reg <= led_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      nack_reg <= nack_next;
    end
  end

  // all outputs come straight from flip-flops

  assign RD_ACK = ack_reg;
  assign RD_NACK = nack_reg;
  assign RD_DATA = rdata_reg;
  assign CH_LED = led_reg;
  assign US_TICKER = tick_reg;

endmodule // amdr_record

/* File: include/amdr_pkg.sv */
// constants of the analog module diagnostic record
package amdr_pkg;
  // byte positions inside the record
  localparam logic [4:0] AMDR_IDX_SUMMARY = 5'h00;
  localparam logic [4:0] AMDR_IDX_INFO = 5'h01;
  localparam logic [4:0] AMDR_IDX_RSVD_C = 5'h02;
  localparam logic [4:0] AMDR_IDX_EXT = 5'h03;
  localparam logic [4:0] AMDR_IDX_CHTYPE = 5'h04;
  localparam logic [4:0] AMDR_IDX_DIAG_BITS_PER_CHANNEL = 5'h05;
  localparam logic [4:0] AMDR_IDX_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] AMDR_IDX_GROUP = 5'h07;
  localparam logic [4:0] AMDR_IDX_CH0 = 5'h08;
  localparam logic [4:0] AMDR_IDX_CH3 = 5'h0B;
  localparam logic [4:0] AMDR_IDX_UNUSED0 = 5'h0C;
  localparam logic [4:0] AMDR_IDX_UNUSED3 = 5'h0F;
  localparam logic [4:0] AMDR_IDX_TS0 = 5'h10;
  localparam logic [4:0] AMDR_IDX_TS3 = 5'h13;
  // last byte index reachable per record set
  localparam logic [4:0] AMDR_LAST_SHORT = 5'h03;
  localparam logic [4:0] AMDR_LAST_FULL = 5'h13;
  // record set numbers
  localparam logic [7:0] AMDR_SET_SHORT = 8'h00;
  localparam logic [7:0] AMDR_SET_FULL = 8'h01;
  // summary byte bit positions
  localparam int AMDR_SUM_FAIL = 0;
  localparam int AMDR_SUM_INT = 1;
  localparam int AMDR_SUM_EXT = 2;
  localparam int AMDR_SUM_CHAN = 3;
  localparam int AMDR_SUM_AUX = 4;
  localparam int AMDR_SUM_PARAM = 7;
  // extended byte bit positions
  localparam int AMDR_EXT_OVF = 3;
  localparam int AMDR_EXT_COMM = 4;
  // per-channel byte bit positions
  localparam int AMDR_CH_PARAM = 0;
  localparam int AMDR_CH_UNDER = 6;
  localparam int AMDR_CH_OVER = 7;
  // constant bytes
  localparam logic [3:0] AMDR_CLASS_ANALOG = 4'h5;
  localparam int AMDR_INFO_CHPRES = 4;
  localparam logic [6:0] AMDR_CHTYPE_DI = 7'h70;
  localparam logic [6:0] AMDR_CHTYPE_AI = 7'h71;
  localparam logic [6:0] AMDR_CHTYPE_DO = 7'h72;
  localparam logic [6:0] AMDR_CHTYPE_AO = 7'h73;
  localparam logic [6:0] AMDR_CHTYPE_AIO = 7'h74;
  localparam logic [6:0] AMDR_CHTYPE_CNT = 7'h76;
  localparam logic [7:0] AMDR_DIAG_BITS_PER_CHANNEL = 8'h08;
  localparam logic [7:0] AMDR_CHANNEL_COUNT = 8'h04;
  localparam int AMDR_CHANNELS = 4;
  // reset values
  localparam logic [7:0] AMDR_BYTE_RST = 8'h00;
  localparam logic [31:0] AMDR_TICK_RST = 32'h0000_0000;
  localparam logic [6:0] AMDR_PRESC_RST = 7'h00;
  // microsecond prescaler
  localparam int AMDR_US_NS = 1000;
  localparam int AMDR_CLK_NS = 8;
  localparam int AMDR_US_CYCLES_INT = AMDR_US_NS / AMDR_CLK_NS;
  localparam logic [6:0] AMDR_US_LAST = 7'(AMDR_US_CYCLES_INT - 1);
endpackage : amdr_pkg

/* File: testbench/amdr_coupler.sv */
// backplane coupler model reading the record
`timescale 1ns/1ps
module amdr_coupler (
  // clock
  input wire logic CLK,
  // read answer
  input wire logic RD_ACK,
  input wire logic RD_NACK,
  input wire logic [7:0] RD_DATA,
  // read request
  output logic RD_REQ,
  output logic [7:0] RECORD_SET_NUMBER,
  output logic [4:0] RD_INDEX
);
  initial {RD_REQ, RECORD_SET_NUMBER, RD_INDEX} = 14'h0000;
  task automatic rd(input logic [7:0] s, input logic [4:0] i,
                    output logic [7:0] d, output logic n, output bit to);
    to = 1'b1;
    @(negedge CLK);
    RD_REQ = 1'b1;
    RECORD_SET_NUMBER = s;
    RD_INDEX = i;
    // answer is registered, so it stands at the falling edge after
    repeat (2) begin
      @(negedge CLK);
      if (to && (RD_ACK || RD_NACK)) begin
        to = 1'b0;
        d = RD_DATA;
        n = RD_NACK;
      end
      // released lines show a changed pattern
      RD_REQ = 1'b0;
      RECORD_SET_NUMBER = ~s;
      RD_INDEX = ~i;
    end
  endtask
endmodule // amdr_coupler

/* File: testbench/amdr_record_bench.sv */
// self-checking bench for the diagnostic record
`timescale 1ns/1ps
module amdr_record_bench;
  import amdr_pkg::*;
  logic CLK, RST_N, MOD_FAIL, INT_ERR, EXT_ERR, AUX_MISSING, PARAM_ERR;
  logic DIAG_BUF_OVF, COMM_ERR, RD_REQ, RD_ACK, RD_NACK;
  logic [3:0] CH_PARAM_ERR, CH_UNDER, CH_OVER, CH_LED;
  logic [7:0] RECORD_SET_NUMBER, RD_DATA;
  logic [4:0] RD_INDEX;
  logic [31:0] US_TICKER, ts;
  logic [6:0] mv;
  int miscompares = 0;
  int total_checks = 0;
  assign {COMM_ERR, DIAG_BUF_OVF, PARAM_ERR, AUX_MISSING} = mv[6:3];
  assign {EXT_ERR, INT_ERR, MOD_FAIL} = mv[2:0];
  amdr_record DUT (.*);
  amdr_coupler cpl (.*);
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // e holds the refusal flag above the data byte
  task automatic rd(input logic [7:0] s, input logic [4:0] i,
                    input logic [8:0] e);
    logic [7:0] d;
    logic n;
    bit to;
    cpl.rd(s, i, d, n, to);
    if (to) begin
      miscompares++;
      close_out();
    end
    chk("read", e, {n, d});
  endtask
  function automatic logic [7:0] rst_byte(int i);
    case (i)
      1: return 8'h15;
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    RST_N = 1'b0;
    mv = 7'h00;
    {CH_PARAM_ERR, CH_UNDER, CH_OVER} = 12'h000;
    repeat (16) @(negedge CLK);
    RST_N = 1'b1;
    chk("ticker", 32'h0, US_TICKER);
    for (int i = 0; i < 20; i++)
      rd(8'h01, 5'(i), {1'b0, rst_byte(i)});
    for (int k = 0; k < 7; k++) begin
      @(negedge CLK) mv = 7'(1 << k);
      rd(8'h00, 5'h00, {1'b0, mv[4], 2'b00, mv[3], 1'b0, mv[2:0]});
      rd(8'h00, 5'h03, {4'h0, mv[6:5], 3'b000});
    end
    for (int ch = 0; ch < 4; ch++)
      for (int kd = 0; kd < 3; kd++) begin
        @(negedge CLK);
        CH_PARAM_ERR = (kd == 0) ? 4'(1 << ch) : 4'h0;
        CH_UNDER = (kd == 1) ? 4'(1 << ch) : 4'h0;
        CH_OVER = (kd == 2) ? 4'(1 << ch) : 4'h0;
        rd(8'h01, 5'(8 + ch), (kd == 0) ? 9'h001 : 9'(8'h20 << kd));
        rd(8'h01, 5'h07, 9'(1 << ch));
        rd(8'h01, 5'h00, 9'h008);
        rd(8'h01, 5'(12 + ch), 9'h000);
        @(negedge CLK);
        chk("led", 32'(1 << ch), CH_LED);
      end
    @(negedge CLK) {CH_PARAM_ERR, CH_UNDER, CH_OVER} = 12'h000;
    mv = 7'h00;
    ts = US_TICKER;
    repeat (125) @(negedge CLK);
    chk("tick", ts + 32'h1, US_TICKER);
    CH_OVER = 4'h2;
    ts = US_TICKER;
    for (int j = 0; j < 4; j++)
      rd(8'h01, 5'(16 + j), {1'b0, ts[8 * j +: 8]});
    rd(8'h02, 5'h00, 9'h100);
    rd(8'h00, 5'h04, 9'h100);
    rd(8'h01, 5'h14, 9'h100);
    rd(8'h00, 5'h03, 9'h000);
    close_out();
  end
endmodule // amdr_record_bench
bind amdr_record amdr_record_chk chk_i (.*);

/* File: testbench/amdr_record_chk.sv */
// assertions on the diagnostic record ports
`timescale 1ns/1ps
module amdr_record_chk
  import amdr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // channel errors
  input wire logic [3:0] CH_PARAM_ERR,
  input wire logic [3:0] CH_UNDER,
  input wire logic [3:0] CH_OVER,
  // read port
  input wire logic RD_REQ,
  input wire logic [7:0] RECORD_SET_NUMBER,
  input wire logic [4:0] RD_INDEX,
  input wire logic RD_ACK,
  input wire logic RD_NACK,
  input wire logic [7:0] RD_DATA,
  // indicators and ticker
  input wire logic [3:0] CH_LED,
  input wire logic [31:0] US_TICKER
);
  logic [7:0] gap_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // edges since the ticker last moved
  always_ff @(posedge CLK) begin
    if (!RST_N || $changed(US_TICKER))
      gap_reg <= 8'h00;
    else
      gap_reg <= gap_reg + 8'h01;
  end
  sequence rd_s(logic [7:0] s, logic [4:0] i);
    RD_REQ && RECORD_SET_NUMBER == s && RD_INDEX == i;
  endsequence
  ack_full_a: assert property (RD_REQ && RECORD_SET_NUMBER == 8'h01 &&
    RD_INDEX <= 5'h13 |=> RD_ACK && !RD_NACK) else $error("no ack");
  bad_set_a: assert property (RD_REQ && RECORD_SET_NUMBER > 8'h01
    |=> RD_NACK && !RD_ACK && RD_DATA == 8'h00) else $error("no nack");
  short_set_a: assert property (rd_s(8'h00, RD_INDEX) &&
    RD_INDEX > 5'h03 |=> RD_NACK) else $error("short set not refused");
  answer_src_a: assert property (RD_ACK || RD_NACK |->
    $past(RD_REQ)) else $error("answer without request");
  led_follow_a: assert property ($past(RST_N) |-> CH_LED ==
    $past(CH_PARAM_ERR | CH_UNDER | CH_OVER)) else $error("led wrong");
  tick_step_a: assert property ($past(RST_N) && $changed(US_TICKER)
    |-> US_TICKER == $past(US_TICKER) + 32'h1) else $error("tick step");
  tick_rate_a: assert property ($changed(US_TICKER) &&
    US_TICKER > 32'h1 |-> gap_reg == 8'h7C) else $error("tick rate");
  diag_bits_per_channel_a: assert property (rd_s(8'h01, 5'h05)
    |=> RD_DATA == 8'h08) else $error("bit count wrong");
  unused_zero_a: assert property (rd_s(8'h01, {3'b011, RD_INDEX[1:0]})
    |=> RD_DATA == 8'h00) else $error("unused byte not zero");
endmodule // amdr_record_chk
